// ### rtl/adc_sequencer.sv
// Conversion sequencer and three-state byte interface of the integrating converter.
`timescale 1ns/10ps
module adc_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire adc_seq_pkg::bus_ctl_type bus_ctl,
    input wire logic [7:0] bus_in,
    input wire adc_seq_pkg::result_type analog_result,
    output logic [7:0] bus_out,
    output logic bus_oe,
    output logic busy,
    output adc_seq_pkg::phase_type phase,
    output logic result_valid
);

    // ****************************************
    // Internal clock enable
    // ****************************************
    logic tick;
    logic half_tick;

    clock_divider u_div (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .half_tick(half_tick)
    );

    // ****************************************
    // Pin synchronisers and internal-clock sampling
    // ****************************************
    adc_seq_pkg::bus_ctl_type s1_r;
    adc_seq_pkg::bus_ctl_type s2_r;
    logic wr_t_r;
    logic rd_t_r;
    logic mode_t_r;
    logic wr_t_nxt;
    logic rd_t_nxt;
    logic mode_t_nxt;

    always_comb begin
        wr_t_nxt = wr_t_r;
        rd_t_nxt = rd_t_r;
        mode_t_nxt = mode_t_r;
        if (tick) begin
            wr_t_nxt = s2_r.wr_n;
            rd_t_nxt = s2_r.rd_n;
            mode_t_nxt = s2_r.run_mode_select;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= '{cs: 1'b0, ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: 1'b0};
            s2_r <= '{cs: 1'b0, ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: 1'b0};
            wr_t_r <= 1'b1;
            rd_t_r <= 1'b1;
            mode_t_r <= 1'b0;
        end else begin
            s1_r <= bus_ctl;
            s2_r <= s1_r;
            wr_t_r <= wr_t_nxt;
            rd_t_r <= rd_t_nxt;
            mode_t_r <= mode_t_nxt;
        end
    end

    logic sel;
    logic cont;
    logic wr_fall;
    logic rd_rise;

    assign sel = s2_r.cs & ~s2_r.ce_n;
    assign cont = mode_t_r;
    // Edges are seen only at internal clock ticks, so pin glitches are filtered.
    assign wr_fall = tick & sel & wr_t_r & ~s2_r.wr_n;
    assign rd_rise = tick & sel & ~rd_t_r & s2_r.rd_n;

    // ****************************************
    // Conversion sequencing
    // ****************************************
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } seq_state_type;

    seq_state_type state_r;
    seq_state_type state_nxt;
    logic [10:0] pos_r;
    logic [10:0] pos_nxt;
    logic [10:0] lock_r;
    logic [10:0] lock_nxt;
    logic pending_r;
    logic pending_nxt;
    logic end_of_conv;

    // The result is taken as the position counter wraps to zero.
    assign end_of_conv = tick & (state_r == ST_RUN) & (pos_r == adc_seq_pkg::POS_LAST);

    always_comb begin
        state_nxt = state_r;
        pos_nxt = pos_r;
        lock_nxt = lock_r;
        pending_nxt = pending_r;
        if (tick) begin
            if (lock_r != 11'h000) begin
                lock_nxt = lock_r - 11'h001;
            end
            case (state_r)
                ST_IDLE: begin
                    if (cont) begin
                        state_nxt = ST_RUN;
                        pos_nxt = pos_r + 11'h001;
                    end else if (wr_fall) begin
                        state_nxt = ST_RUN;
                        pos_nxt = pos_r + 11'h001;
                        lock_nxt = adc_seq_pkg::LOCK_LOAD;
                    end
                end
                ST_RUN: begin
                    if (pos_r == adc_seq_pkg::POS_LAST) begin
                        pos_nxt = 11'h000;
                    end else begin
                        pos_nxt = pos_r + 11'h001;
                    end
                    if (cont) begin
                        pending_nxt = 1'b0;
                    end else if (wr_fall && lock_r == 11'h000) begin
                        pending_nxt = 1'b1;
                    end
                    // A demand conversion parks where the next strobe would start it.
                    if (!cont && pos_r == adc_seq_pkg::POS_DEMAND_START - 11'h001) begin
                        if (pending_r || (wr_fall && lock_r == 11'h000)) begin
                            pending_nxt = 1'b0;
                            lock_nxt = adc_seq_pkg::LOCK_LOAD;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    pos_nxt = adc_seq_pkg::POS_DEMAND_START;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            pos_r <= adc_seq_pkg::POS_DEMAND_START;
            lock_r <= 11'h000;
            pending_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pos_r <= pos_nxt;
            lock_r <= lock_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ****************************************
    // End-of-conversion flag and phase
    // ****************************************
    logic busy_nxt;
    adc_seq_pkg::phase_type phase_nxt;

    always_comb begin
        busy_nxt = (state_nxt == ST_RUN) && (pos_nxt >= adc_seq_pkg::POS_BUSY_RISE);
        if (pos_nxt < adc_seq_pkg::POS_SIGNAL) begin
            phase_nxt = adc_seq_pkg::PH_ZERO;
        end else if (pos_nxt < adc_seq_pkg::POS_DEINT) begin
            phase_nxt = adc_seq_pkg::PH_SIGNAL;
        end else begin
            phase_nxt = adc_seq_pkg::PH_DEINT;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            phase <= adc_seq_pkg::PH_ZERO;
        end else begin
            busy <= busy_nxt;
            phase <= phase_nxt;
        end
    end

    // ****************************************
    // Result latch and byte counter
    // ****************************************
    adc_seq_pkg::result_type res_r;
    adc_seq_pkg::result_type res_nxt;
    logic valid_r;
    logic valid_nxt;
    logic [1:0] byte_r;
    logic [1:0] byte_nxt;

    // Beyond full scale the magnitude is limited to the extended count range.
    function automatic adc_seq_pkg::result_type limit_result(
        input adc_seq_pkg::result_type r
    );
        adc_seq_pkg::result_type o;
        o = r;
        if (r.overrange) begin
            o.magnitude[14:8] = 7'h00;
            if (r.magnitude[7:0] > adc_seq_pkg::OVR_LOW_MAX) begin
                o.magnitude[7:0] = adc_seq_pkg::OVR_LOW_MAX;
            end
        end
        return o;
    endfunction

    always_comb begin
        res_nxt = res_r;
        valid_nxt = valid_r;
        byte_nxt = byte_r;
        if (end_of_conv) begin
            res_nxt = limit_result(analog_result);
            valid_nxt = 1'b1;
            byte_nxt = adc_seq_pkg::BYTE_FIRST;
        end else if (cont && half_tick && state_r == ST_RUN
                     && pos_r == adc_seq_pkg::POS_CLEAR) begin
            res_nxt = '0;
            valid_nxt = 1'b0;
            byte_nxt = adc_seq_pkg::BYTE_FIRST;
        end else if (cont && rd_rise) begin
            if (byte_r == adc_seq_pkg::BYTE_THIRD) begin
                byte_nxt = adc_seq_pkg::BYTE_FIRST;
            end else begin
                byte_nxt = byte_r + 2'h1;
            end
        end
        // A result that completes in the tick of an accepted strobe is still published.
        if (!cont && wr_fall && !end_of_conv && (state_r == ST_IDLE || lock_r == 11'h000)) begin
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            res_r <= '0;
            valid_r <= 1'b0;
            byte_r <= adc_seq_pkg::BYTE_FIRST;
        end else begin
            res_r <= res_nxt;
            valid_r <= valid_nxt;
            byte_r <= byte_nxt;
        end
    end

    assign result_valid = valid_r;

    // ****************************************
    // Three-state data bus
    // ****************************************
    logic low_pick;
    logic ovr_pick;
    logic [7:0] bus_nxt;
    logic oe_nxt;

    always_comb begin
        if (cont) begin
            low_pick = (byte_r == adc_seq_pkg::BYTE_SECOND);
            ovr_pick = (byte_r == adc_seq_pkg::BYTE_THIRD);
        end else begin
            low_pick = s2_r.byte_sel;
            ovr_pick = s2_r.sign_flag_select;
        end
        if (low_pick) begin
            bus_nxt = res_r.magnitude[7:0];
        end else if (ovr_pick) begin
            bus_nxt = {res_r.overrange, res_r.magnitude[14:8]};
        end else begin
            bus_nxt = {res_r.positive, res_r.magnitude[14:8]};
        end
        oe_nxt = sel & ~s2_r.rd_n;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_out <= 8'h00;
            bus_oe <= 1'b0;
        end else begin
            bus_out <= bus_nxt;
            bus_oe <= oe_nxt;
        end
    end

    // The data bus level during a convert strobe carries nothing; bus_in is not read.

endmodule

// ### rtl/adc_seq_pkg.sv
// Package holding constants and carrier types of the integrating converter sequencer.
package adc_seq_pkg;

    // ****************************************
    // Clock division
    // ****************************************
    localparam int unsigned DIV_RATIO = 4;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam logic [1:0] DIV_HALF = 2'h1;

    // ****************************************
    // Conversion timing in internal clock periods
    // ****************************************
    localparam int unsigned CONV_TICKS = 1280;
    localparam int unsigned ZERO_TICKS = 246;
    localparam int unsigned SIGNAL_TICKS = 256;
    localparam int unsigned BUSY_TICKS = 836;
    localparam int unsigned DEMAND_TO_FALL = 1155;
    localparam int unsigned LOCKOUT_TICKS = 1100;

    localparam logic [10:0] POS_LAST = 11'(CONV_TICKS - 1);
    localparam logic [10:0] POS_SIGNAL = 11'(ZERO_TICKS);
    localparam logic [10:0] POS_DEINT = 11'(ZERO_TICKS + SIGNAL_TICKS);
    localparam logic [10:0] POS_BUSY_RISE = 11'(CONV_TICKS - BUSY_TICKS);
    localparam logic [10:0] POS_CLEAR = 11'(CONV_TICKS - BUSY_TICKS - 1);
    localparam logic [10:0] POS_DEMAND_START = 11'(CONV_TICKS - DEMAND_TO_FALL);
    localparam logic [10:0] LOCK_LOAD = 11'(LOCKOUT_TICKS);

    // ****************************************
    // Result encoding
    // ****************************************
    localparam logic [7:0] OVR_LOW_MAX = 8'hbe;
    localparam logic [1:0] BYTE_FIRST = 2'h0;
    localparam logic [1:0] BYTE_SECOND = 2'h1;
    localparam logic [1:0] BYTE_THIRD = 2'h2;

    typedef enum logic [1:0] {
        PH_ZERO,
        PH_SIGNAL,
        PH_DEINT
    } phase_type;

    typedef struct packed {
        logic positive;
        logic overrange;
        logic [14:0] magnitude;
    } result_type;

    typedef struct packed {
        logic cs;
        logic ce_n;
        logic rd_n;
        logic wr_n;
        logic byte_sel;
        logic sign_flag_select;
        logic run_mode_select;
    } bus_ctl_type;

endpackage

// ### rtl/clock_divider.sv
// Divide-by-four enable generator giving the internal conversion clock.
`timescale 1ns/10ps
module clock_divider (
    input wire logic mclk,
    input wire logic rst,
    output logic tick,
    output logic half_tick
);

    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 2'h1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // One pulse every fourth cycle, and one midway between two of them.
    assign tick = (cnt_r == adc_seq_pkg::DIV_LAST);
    assign half_tick = (cnt_r == adc_seq_pkg::DIV_HALF);

endmodule

// ### verif/adc_sequencer_sva.sv
// Port assertions for the converter sequencer.
`timescale 1ns/10ps
module adc_sequencer_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire adc_seq_pkg::bus_ctl_type bus_ctl,
    input wire logic [7:0] bus_in,
    input wire adc_seq_pkg::result_type analog_result,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    input wire logic busy,
    input wire adc_seq_pkg::phase_type phase,
    input wire logic result_valid
);
    logic act;
    logic cont;
    logic [11:0] hi_r, hi_nxt, lo_r, lo_nxt, sig_r, sig_nxt;
    logic [13:0] run_r, run_nxt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    assign act = bus_ctl.cs & ~bus_ctl.ce_n & ~bus_ctl.rd_n;
    assign cont = run_r > 14'h1f40;
    always_comb begin
        hi_nxt = busy ? hi_r + 12'h001 : 12'h000;
        lo_nxt = busy ? 12'h000 : lo_r + 12'h001;
        sig_nxt = (phase == adc_seq_pkg::PH_SIGNAL) ? sig_r + 12'h001 : 12'h000;
        run_nxt = !bus_ctl.run_mode_select ? 14'h0000 : run_r + {13'h0000, run_r != 14'h3fff};
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            hi_r <= 12'h000;
            lo_r <= 12'h000;
            sig_r <= 12'h000;
            run_r <= 14'h0000;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            sig_r <= sig_nxt;
            run_r <= run_nxt;
        end
    end
    oe_cause_a: assert property (bus_oe |-> $past(act, 3))
        else $error("bus driven without select and read");
    oe_drive_a: assert property ($past(act, 3) && $past(act, 4) |-> bus_oe)
        else $error("bus not driven during selected read");
    busy_len_a: assert property ($fell(busy) |-> hi_r == 12'hd10)
        else $error("busy high time wrong");
    cont_gap_a: assert property ($rose(busy) && cont |-> lo_r == 12'h6f0)
        else $error("continuous busy low time wrong");
    valid_fall_a: assert property ($fell(busy) |-> result_valid)
        else $error("result not valid at busy fall");
    clear_pt_a: assert property ($rose(busy) && cont |-> !$past(result_valid) && $past(result_valid, 4))
        else $error("result not cleared just before busy rise");
    busy_phase_a: assert property ($rose(busy) |-> phase == adc_seq_pkg::PH_SIGNAL)
        else $error("busy rose in wrong phase");
    end_phase_a: assert property ($fell(busy) |-> ##[0:4] phase == adc_seq_pkg::PH_ZERO)
        else $error("no zero phase after busy fall");
    sig_len_a: assert property ($past(phase) == adc_seq_pkg::PH_SIGNAL && phase != adc_seq_pkg::PH_SIGNAL |-> sig_r == 12'h400)
        else $error("signal phase length wrong");
    cover property ($fell(busy));
    cover property ($rose(bus_oe));
    cover property ($rose(busy) && cont);
endmodule

// ### verif/bus_host_model.sv
// Host side of the three-state data bus.
`timescale 1ns/10ps
module bus_host_model (
    input wire logic mclk,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    output logic [7:0] bus_seen,
    output logic [7:0] bus_wdata
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] wd_r = 8'ha5;
    // A released bus shows the inverse of its last driven value.
    assign bus_seen = bus_oe ? bus_out : ~last_r;
    assign bus_wdata = wd_r;
    always_ff @(posedge mclk) begin
        if (bus_oe) begin
            last_r <= bus_out;
        end
        wd_r <= wd_r + 8'h5b;
    end
endmodule

// ### verif/tb_adc_sequencer.sv
// Self-checking bench of the converter sequencer.
`timescale 1ns/10ps
module tb_adc_sequencer;
    localparam int LAT = 4 * adc_seq_pkg::DEMAND_TO_FALL;
    localparam int HI = 4 * adc_seq_pkg::BUSY_TICKS;
    localparam int GAP = 4 * (adc_seq_pkg::CONV_TICKS - adc_seq_pkg::BUSY_TICKS);
    logic mclk = 1'b0;
    logic rst = 1'b1;
    adc_seq_pkg::bus_ctl_type ctl = 7'h58;
    adc_seq_pkg::result_type res = 17'h00000;
    adc_seq_pkg::phase_type phase;
    logic [7:0] bus_out, bus_seen, wdata, rd_d;
    logic bus_oe, busy, valid, rd_oe;
    logic [31:0] seed = 32'h0000acaf;
    int err_total = 0;
    int cmp_count = 0;
    int n, cyc, t0, t_str, lat;
    always #20 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    adc_sequencer dut (.mclk(mclk), .rst(rst), .bus_ctl(ctl), .bus_in(wdata),
        .analog_result(res), .bus_out(bus_out), .bus_oe(bus_oe), .busy(busy),
        .phase(phase), .result_valid(valid));
    bus_host_model host (.mclk(mclk), .bus_out(bus_out), .bus_oe(bus_oe),
        .bus_seen(bus_seen), .bus_wdata(wdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_byte(input adc_seq_pkg::result_type r, input logic lo,
                                            input logic ovs);
        logic [7:0] l;
        l = (r.overrange && r.magnitude[7:0] > 8'hbe) ? 8'hbe : r.magnitude[7:0];
        if (lo) return l;
        return {ovs ? r.overrange : r.positive, r.overrange ? 7'h00 : r.magnitude[14:8]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge mclk);
    endtask
    task automatic wait_busy(input logic lvl);
        n = 0;
        while (busy !== lvl) begin
            @(negedge mclk);
            n++;
            if (n > 6000) begin
                err_total++;
                wrap_up();
            end
        end
    endtask
    task automatic rd(input logic lo, input logic ovs);
        @(posedge mclk);
        ctl.byte_sel <= lo;
        ctl.sign_flag_select <= ovs;
        ctl.rd_n <= 1'b0;
        tk(8);
        @(negedge mclk);
        rd_d = bus_seen;
        rd_oe = bus_oe;
        @(posedge mclk);
        ctl.rd_n <= 1'b1;
        tk(8);
    endtask
    task automatic strobe();
        @(posedge mclk);
        t_str = cyc;
        ctl.wr_n <= 1'b0;
        tk(8);
        ctl.wr_n <= 1'b1;
    endtask
    task automatic rd_all();
        for (int k = 0; k < 3; k++) begin
            rd(k == 2, k == 1);
            chk(16'(rd_d), 16'(exp_byte(res, k == 2, k == 1)));
        end
    endtask
    initial begin
        tk(3);
        rst <= 1'b0;
        tk(8);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            res <= (i == 1) ? 17'h1ffff : (i == 2) ? 17'h0c0be : seed[16:0];
            strobe();
            t0 = t_str;
            tk(200);
            strobe();
            wait_busy(1'b1);
            wait_busy(1'b0);
            chk(16'(n), 16'(HI));
            lat = cyc - t0;
            chk(16'(lat >= LAT && lat <= LAT + 16), 16'h0001);
            tk(1900);
            @(negedge mclk);
            chk(16'(busy), 16'h0000);
            chk(16'(valid), 16'h0001);
            chk(16'(phase), 16'(adc_seq_pkg::PH_ZERO));
            rd_all();
        end
        for (int j = 0; j < 2; j++) begin
            ctl.cs <= j[0];
            ctl.ce_n <= j[0];
            strobe();
            rd(1'b0, 1'b0);
            chk(16'(rd_oe), 16'h0000);
            tk(1900);
            @(negedge mclk);
            chk(16'(busy), 16'h0000);
            chk(16'(valid), 16'h0001);
            @(posedge mclk);
        end
        ctl.cs <= 1'b1;
        ctl.ce_n <= 1'b0;
        strobe();
        wait_busy(1'b1);
        chk(16'(valid), 16'h0000);
        tk(HI - 150);
        strobe();
        wait_busy(1'b0);
        t0 = cyc;
        wait_busy(1'b1);
        chk(16'(cyc - t0), 16'(GAP));
        wait_busy(1'b0);
        @(posedge mclk);
        ctl.run_mode_select <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wait_busy(1'b1);
            seed = xs(seed);
            @(posedge mclk);
            res <= seed[16:0];
            wait_busy(1'b0);
            chk(16'(valid), 16'h0001);
            for (int k = 0; k < 4; k++) begin
                rd(seed[k], seed[k + 4]);
                chk(16'(rd_d), 16'(exp_byte(res, k % 3 == 1, k % 3 == 2)));
            end
        end
        wrap_up();
    end
endmodule
bind adc_sequencer adc_sequencer_sva chk_i (.mclk(mclk), .rst(rst), .bus_ctl(bus_ctl),
    .bus_in(bus_in), .analog_result(analog_result), .bus_out(bus_out), .bus_oe(bus_oe),
    .busy(busy), .phase(phase), .result_valid(result_valid));
